// ===== inc/crtc_defs.svh
// constants for the raster timing controller: register indices, fields,
// reset values and timing figures
// assumes inclusion by bare name from inc/
`ifndef CRTC_DEFS_SVH
`define CRTC_DEFS_SVH

`define CRTC_NUM_REGS 18
`define CRTC_IDX_HTOTAL 5'h00
`define CRTC_IDX_HDISP 5'h01
`define CRTC_IDX_HSPOS 5'h02
`define CRTC_IDX_SYNCW 5'h03
`define CRTC_IDX_VTOTAL 5'h04
`define CRTC_IDX_VADJ 5'h05
`define CRTC_IDX_VDISP 5'h06
`define CRTC_IDX_VSPOS 5'h07
`define CRTC_IDX_SCAN_DELAY 5'h08
`define CRTC_IDX_MAXROW 5'h09
`define CRTC_IDX_CUR_FIRST 5'h0a
`define CRTC_IDX_CUR_LAST 5'h0b
`define CRTC_IDX_START_H 5'h0c
`define CRTC_IDX_START_L 5'h0d
`define CRTC_IDX_CUR_H 5'h0e
`define CRTC_IDX_CUR_L 5'h0f
`define CRTC_IDX_PEN_H 5'h10
`define CRTC_IDX_PEN_L 5'h11
// skew field positions in the scan and delay register
`define CRTC_WIN_DLY_LSB 4
`define CRTC_CUR_DLY_LSB 6
// cursor mode field position in cursor first-row register
`define CRTC_CUR_MODE_LSB 5
`define CRTC_BLINK_FAST_FIELDS 16
`define CRTC_BLINK_SLOW_FIELDS 32
// character clock: one tick per four system clocks by default
`define CRTC_CHAR_DIV 4'h2
`define CRTC_REG_RESET 8'h00

`endif

// ===== inc/crtc_pkg.sv
// types shared by both ends of the raster timing controller
// assumes crtc_defs.svh is reachable on the include path
`default_nettype none
package crtc_pkg;
  typedef logic [13:0] crtc_addr_t;
  typedef logic [4:0] crtc_row_t;
  typedef logic [7:0] crtc_byte_t;
  typedef enum logic [1:0] {
    CRTC_CUR_STEADY,
    CRTC_CUR_OFF,
    CRTC_CUR_BLINK_FAST,
    CRTC_CUR_BLINK_SLOW
  } crtc_cur_mode_t;
  typedef enum {
    CRTC_HOST_IDLE,
    CRTC_HOST_STROBE,
    CRTC_HOST_DONE
  } crtc_host_state_t;
endpackage : crtc_pkg
`default_nettype wire

// ===== inc/crtc_if.sv
// processor bus plus video outputs between host and controller
// assumes one common clock; data bus split into in, out and enable
`timescale 1ns/10ps
`default_nettype none
interface crtc_if;
  import crtc_pkg::*;
  logic chip_sel_n;
  logic register_select;
  logic read_not_write;
  logic bus_enable;
  logic chip_clear_n;
  crtc_byte_t wdata;
  crtc_byte_t rdata;
  logic rdata_oe;
  logic char_clk;
  crtc_addr_t refresh_mem_addr;
  crtc_row_t char_row_line;
  logic display_window;
  logic cursor_video;
  logic hsync;
  logic vsync;
  modport device (
    input chip_sel_n, register_select, read_not_write, bus_enable,
    input chip_clear_n, wdata, char_clk,
    output rdata, rdata_oe, refresh_mem_addr, char_row_line,
    output display_window, cursor_video, hsync, vsync
  );
  modport host (
    output chip_sel_n, register_select, read_not_write, bus_enable,
    output chip_clear_n, wdata, char_clk,
    input rdata, rdata_oe, refresh_mem_addr, char_row_line,
    input display_window, cursor_video, hsync, vsync
  );
endinterface : crtc_if
`default_nettype wire

// ===== rtl/crtc_skew.sv
// delays one video flag by 0, 1 or 2 character times
// assumes tick marks the character clock rising edge
`timescale 1ns/10ps
`default_nettype none
module crtc_skew (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic tick,
  input wire logic [1:0] delay_sel,
  input wire logic din,
  // result
  output logic dout
);
  import crtc_pkg::*;
  logic [1:0] pipe_q;
  logic sel_w;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pipe_q <= 2'h0;
    end else if (tick) begin
      pipe_q <= {pipe_q[0], din};
    end
  end

  // code 3 is undefined; treated as two characters
  assign sel_w = (delay_sel == 2'h0) ? din :
                 (delay_sel == 2'h1) ? pipe_q[0] : pipe_q[1];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dout <= 1'b0;
    end else begin
      dout <= sel_w;
    end
  end
endmodule : crtc_skew
`default_nettype wire

// ===== rtl/crtc_device.sv
// raster timing controller: indexed register file and video timing
// assumes bus and character clock signals synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "crtc_defs.svh"
module crtc_device (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  crtc_if.device bus
);
  import crtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [4:0] index_q;
  logic [7:0] regs_q [`CRTC_NUM_REGS];
  logic [7:0] rdata_q;
  logic rdata_oe_q;
  logic strobe_q;
  logic sel_w;
  logic strobe_rise_w;
  logic wr_w;
  logic idx_ok_w;

  assign sel_w = !bus.chip_sel_n && bus.bus_enable;
  assign strobe_rise_w = sel_w && !strobe_q;
  assign wr_w = strobe_rise_w && !bus.read_not_write;
  assign idx_ok_w = index_q < 5'(`CRTC_NUM_REGS);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= sel_w;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      index_q <= 5'h00;
    end else if (wr_w && !bus.register_select) begin
      index_q <= bus.wdata[4:0];
    end
  end

  // chip clear is not a reset for this array: contents survive it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `CRTC_NUM_REGS; i++) begin
        regs_q[i] <= `CRTC_REG_RESET;
      end
    end else if (wr_w && bus.register_select && idx_ok_w &&
                 index_q < `CRTC_IDX_PEN_H) begin
      regs_q[index_q] <= bus.wdata;
    end
  end

  // reads while strobe is high and the device drives the bus
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      rdata_oe_q <= 1'b0;
    end else begin
      rdata_oe_q <= sel_w && bus.read_not_write;
      if (!bus.register_select) begin
        rdata_q <= {3'h0, index_q};
      end else if (idx_ok_w) begin
        rdata_q <= regs_q[index_q];
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign bus.rdata = rdata_q;
  assign bus.rdata_oe = rdata_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // character clock edge
  logic cclk_q;
  logic tick_w;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cclk_q <= 1'b0;
    end else begin
      cclk_q <= bus.char_clk;
    end
  end
  // counters move on the low-to-high edge at mid character
  assign tick_w = bus.char_clk && !cclk_q;

  ////////////////////////////////////////////////////////////////////////
  // counters
  logic [7:0] hcnt_q;
  logic [4:0] row_q;
  logic [6:0] vcnt_q;
  logic [4:0] adj_q;
  logic in_adj_q;
  logic [13:0] line_base_q;
  logic [13:0] addr_q;
  logic [3:0] hsw_q;
  logic [3:0] vsw_q;
  logic hsync_q;
  logic vsync_q;
  logic [4:0] field_q;
  logic clear_w;
  logic h_end_w;
  logic row_end_w;
  logic v_end_w;
  logic frame_end_w;
  logic [13:0] start_w;
  logic [13:0] cursor_w;

  assign clear_w = !bus.chip_clear_n;
  assign start_w = {regs_q[`CRTC_IDX_START_H][5:0],
                    regs_q[`CRTC_IDX_START_L]};
  assign cursor_w = {regs_q[`CRTC_IDX_CUR_H][5:0],
                     regs_q[`CRTC_IDX_CUR_L]};
  assign h_end_w = hcnt_q == regs_q[`CRTC_IDX_HTOTAL];
  assign row_end_w = h_end_w && (row_q == regs_q[`CRTC_IDX_MAXROW][4:0]);
  assign v_end_w = vcnt_q == regs_q[`CRTC_IDX_VTOTAL][6:0];
  assign frame_end_w = h_end_w &&
    (in_adj_q ? (adj_q == regs_q[`CRTC_IDX_VADJ][4:0]) :
     (row_end_w && v_end_w && regs_q[`CRTC_IDX_VADJ][4:0] == 5'h00));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hcnt_q <= 8'h00;
      row_q <= 5'h00;
      vcnt_q <= 7'h00;
      adj_q <= 5'h00;
      in_adj_q <= 1'b0;
      line_base_q <= 14'h0000;
      addr_q <= 14'h0000;
      field_q <= 5'h00;
    end else if (clear_w) begin
      hcnt_q <= 8'h00;
      row_q <= 5'h00;
      vcnt_q <= 7'h00;
      adj_q <= 5'h00;
      in_adj_q <= 1'b0;
      line_base_q <= start_w;
      addr_q <= start_w;
    end else if (tick_w) begin
      hcnt_q <= h_end_w ? 8'h00 : hcnt_q + 8'h01;
      addr_q <= addr_q + 14'h0001;
      if (frame_end_w) begin
        row_q <= 5'h00;
        vcnt_q <= 7'h00;
        adj_q <= 5'h00;
        in_adj_q <= 1'b0;
        line_base_q <= start_w;
        addr_q <= start_w;
        field_q <= field_q + 5'h01;
      end else if (in_adj_q && h_end_w) begin
        adj_q <= adj_q + 5'h01;
        addr_q <= line_base_q;
      end else if (row_end_w) begin
        row_q <= 5'h00;
        if (v_end_w) begin
          in_adj_q <= 1'b1;
        end else begin
          vcnt_q <= vcnt_q + 7'h01;
        end
        line_base_q <= line_base_q + {6'h00, regs_q[`CRTC_IDX_HDISP]};
        addr_q <= line_base_q + {6'h00, regs_q[`CRTC_IDX_HDISP]};
      end else if (h_end_w) begin
        row_q <= row_q + 5'h01;
        addr_q <= line_base_q;
      end
    end
  end

  // sync generators; widths of zero are taken as 16
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
      hsw_q <= 4'h0;
      vsw_q <= 4'h0;
    end else if (clear_w) begin
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
    end else if (tick_w) begin
      if (hcnt_q == regs_q[`CRTC_IDX_HSPOS]) begin
        hsync_q <= 1'b1;
        hsw_q <= regs_q[`CRTC_IDX_SYNCW][3:0] - 4'h1;
      end else if (hsw_q == 4'h0) begin
        hsync_q <= 1'b0;
      end else begin
        hsw_q <= hsw_q - 4'h1;
      end
      if (h_end_w && row_end_w && !in_adj_q &&
          vcnt_q + 7'h01 == regs_q[`CRTC_IDX_VSPOS][6:0]) begin
        vsync_q <= 1'b1;
        vsw_q <= regs_q[`CRTC_IDX_SYNCW][7:4] - 4'h1;
      end else if (h_end_w && vsync_q) begin
        if (vsw_q == 4'h0) begin
          vsync_q <= 1'b0;
        end else begin
          vsw_q <= vsw_q - 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window, cursor and skew
  logic window_w;
  logic cursor_w_raw;
  logic blink_on_w;
  crtc_cur_mode_t mode_w;
  logic [4:0] first_w;
  logic [4:0] last_w;

  assign window_w = !in_adj_q && hcnt_q < regs_q[`CRTC_IDX_HDISP] &&
                    vcnt_q < regs_q[`CRTC_IDX_VDISP][6:0];
  assign mode_w = crtc_cur_mode_t'(
    regs_q[`CRTC_IDX_CUR_FIRST][`CRTC_CUR_MODE_LSB +: 2]);
  assign first_w = regs_q[`CRTC_IDX_CUR_FIRST][4:0];
  assign last_w = regs_q[`CRTC_IDX_CUR_LAST][4:0];
  // blink duty is half the period: bit 3 for 16 fields, bit 4 for 32
  assign blink_on_w = (mode_w == CRTC_CUR_STEADY) ||
    (mode_w == CRTC_CUR_BLINK_FAST && !field_q[3]) ||
    (mode_w == CRTC_CUR_BLINK_SLOW && !field_q[4]);
  // relies on software ordering first <= last <= max row
  assign cursor_w_raw = window_w && addr_q == cursor_w &&
    row_q >= first_w && row_q <= last_w && blink_on_w;

  crtc_skew u_win_skew (
    .clk(clk),
    .reset(reset),
    .tick(tick_w),
    .delay_sel(regs_q[`CRTC_IDX_SCAN_DELAY][`CRTC_WIN_DLY_LSB +: 2]),
    .din(window_w),
    .dout(bus.display_window)
  );
  crtc_skew u_cur_skew (
    .clk(clk),
    .reset(reset),
    .tick(tick_w),
    .delay_sel(regs_q[`CRTC_IDX_SCAN_DELAY][`CRTC_CUR_DLY_LSB +: 2]),
    .din(cursor_w_raw),
    .dout(bus.cursor_video)
  );

  assign bus.refresh_mem_addr = addr_q;
  assign bus.char_row_line = row_q;
  assign bus.hsync = hsync_q;
  assign bus.vsync = vsync_q;
endmodule : crtc_device
`default_nettype wire

// ===== rtl/crtc_host.sv
// processor side: bus accesses, chip clear and character clock
// assumes one request at a time held until done
`timescale 1ns/10ps
`default_nettype none
`include "crtc_defs.svh"
module crtc_host (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request
  input wire logic req,
  input wire logic req_sel,
  input wire logic req_read,
  input wire logic [7:0] req_wdata,
  input wire logic clear_req,
  output logic done,
  output logic [7:0] rdata,
  // video latched once toward the serializer
  output logic window_q,
  output logic cursor_q,
  // link
  crtc_if.host bus
);
  import crtc_pkg::*;
  crtc_host_state_t st_q;
  logic [3:0] div_q;
  logic cclk_q;
  logic sel_q;
  logic rd_q;
  logic en_q;
  logic [7:0] wd_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 4'h0;
      cclk_q <= 1'b0;
    end else if (div_q == `CRTC_CHAR_DIV - 4'h1) begin
      div_q <= 4'h0;
      cclk_q <= !cclk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= CRTC_HOST_IDLE;
      sel_q <= 1'b0;
      rd_q <= 1'b1;
      en_q <= 1'b0;
      wd_q <= 8'h00;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (st_q)
        CRTC_HOST_IDLE: begin
          // done still showing: the user drops req only at this edge
          if (req && !done) begin
            sel_q <= req_sel;
            rd_q <= req_read;
            wd_q <= req_wdata;
            en_q <= 1'b1;
            st_q <= CRTC_HOST_STROBE;
          end
        end
        CRTC_HOST_STROBE: begin
          st_q <= CRTC_HOST_DONE;
        end
        CRTC_HOST_DONE: begin
          en_q <= 1'b0;
          rdata <= bus.rdata;
          done <= 1'b1;
          st_q <= CRTC_HOST_IDLE;
        end
        default: st_q <= CRTC_HOST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      window_q <= 1'b0;
      cursor_q <= 1'b0;
    end else begin
      window_q <= bus.display_window;
      cursor_q <= bus.cursor_video;
    end
  end

  assign bus.chip_sel_n = !en_q;
  assign bus.register_select = sel_q;
  assign bus.read_not_write = rd_q;
  assign bus.bus_enable = en_q;
  assign bus.wdata = wd_q;
  assign bus.chip_clear_n = !clear_req;
  assign bus.char_clk = cclk_q;
endmodule : crtc_host
`default_nettype wire

// ===== verif/crtc_properties.sv
// checker for the link between host and raster controller
// assumes one clock, reset active high; sees crtc_if signals only
`timescale 1ns/10ps
`default_nettype none
module crtc_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor bus
  input wire logic chip_sel_n,
  input wire logic read_not_write,
  input wire logic bus_enable,
  input wire logic chip_clear_n,
  input wire logic rdata_oe,
  input wire logic char_clk,
  // video
  input wire crtc_pkg::crtc_addr_t refresh_mem_addr,
  input wire crtc_pkg::crtc_row_t char_row_line,
  input wire logic display_window,
  input wire logic cursor_video,
  input wire logic hsync,
  input wire logic vsync
);
  import crtc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  char_low_a: assert property (
    $fell(char_clk) |=> !char_clk ##1 char_clk)
    else $error("char clock low phase length");
  char_high_a: assert property (
    $rose(char_clk) |=> char_clk ##1 !char_clk)
    else $error("char clock high phase length");
  oe_cause_a: assert property (
    rdata_oe |-> !$past(chip_sel_n) && $past(bus_enable)
      && $past(read_not_write))
    else $error("read data driven without read strobe");
  read_drive_a: assert property (
    (!chip_sel_n && bus_enable && read_not_write) [*2] |-> rdata_oe)
    else $error("selected read not answered");
  write_quiet_a: assert property (
    !chip_sel_n && bus_enable && !read_not_write |-> !rdata_oe)
    else $error("read data driven during write");
  idle_quiet_a: assert property (
    chip_sel_n && $past(chip_sel_n) |-> !rdata_oe)
    else $error("read data driven while deselected");
  clear_rows_a: assert property (
    !chip_clear_n [*3] |-> char_row_line == 5'h00 && !hsync && !vsync)
    else $error("counters run during chip clear");
  // a step is allowed one or two clocks after a char clock rise
  addr_step_a: assert property (
    $changed(refresh_mem_addr) && $past(chip_clear_n)
      && $past(chip_clear_n, 2)
    |-> ($past(char_clk) && !$past(char_clk, 2))
      || ($past(char_clk, 2) && !$past(char_clk, 3)))
    else $error("refresh address moved off a character tick");
  retrace_step_a: assert property (
    disable iff (reset || !chip_clear_n)
    hsync |-> ##[1:6] refresh_mem_addr != $past(refresh_mem_addr))
    else $error("refresh address stalled in retrace");
  retrace_blank_a: assert property (
    disable iff (reset || !chip_clear_n)
    hsync || vsync |-> !display_window)
    else $error("window open during sync");
  cursor_blank_a: assert property (
    cursor_video |-> !hsync && !vsync)
    else $error("cursor shown during sync");
endmodule : crtc_properties
`default_nettype wire

// ===== verif/testbench.sv
// bench: host and controller joined by crtc_if
// assumes design files and crtc_pkg compiled first
`timescale 1ns/10ps
`default_nettype none
`include "crtc_defs.svh"
module testbench;
  import crtc_pkg::*;
  typedef struct {logic rd; crtc_byte_t exp;} crtc_note_t;
  localparam int CHAR_CLKS = 2 * `CRTC_CHAR_DIV;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic req_sel = 1'b0;
  logic req_read = 1'b0;
  logic [7:0] req_wdata = 8'h00;
  logic clear_req = 1'b1;
  logic done;
  logic [7:0] rdata;
  logic [31:0] rnd;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 86229;
  int i, m, w0, c0, dw, hits;
  int hitsq, nexp;
  logic on, onq;
  logic cur_q;
  crtc_note_t notes[$];
  // 12 chars, 5 rows of 3 lines; sync kept clear of skewed window
  crtc_byte_t cfg[16] = '{8'h0b, 8'h04, 8'h07, 8'h12, 8'h04, 8'h00,
    8'h03, 8'h04, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00,
    8'h05};
  crtc_if bus_if();
  always #2 clk = ~clk;
  crtc_host i_crtc_host (.clk(clk), .reset(reset), .req(req),
    .req_sel(req_sel), .req_read(req_read), .req_wdata(req_wdata),
    .clear_req(clear_req), .done(done), .rdata(rdata), .window_q(),
    .cursor_q(cur_q), .bus(bus_if.host));
  crtc_device i_crtc_device (.clk(clk), .reset(reset),
    .bus(bus_if.device));
  crtc_properties i_crtc_properties (.clk(clk), .reset(reset),
    .chip_sel_n(bus_if.chip_sel_n), .read_not_write(bus_if.read_not_write),
    .bus_enable(bus_if.bus_enable), .chip_clear_n(bus_if.chip_clear_n),
    .rdata_oe(bus_if.rdata_oe), .char_clk(bus_if.char_clk),
    .refresh_mem_addr(bus_if.refresh_mem_addr),
    .char_row_line(bus_if.char_row_line),
    .display_window(bus_if.display_window),
    .cursor_video(bus_if.cursor_video), .hsync(bus_if.hsync),
    .vsync(bus_if.vsync));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task automatic acc(input logic sel, input logic rdn, input crtc_byte_t wd,
      input crtc_byte_t exp);
    int k;
    notes.push_back('{rdn, exp});
    req <= 1'b1;
    req_sel <= sel;
    req_read <= rdn;
    req_wdata <= wd;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    req <= 1'b0;
    if (k == 20) begin
      n_errors++;
      end_sim();
    end
    // spacing the host asks between requests
    repeat (3) @(posedge clk);
  endtask : acc
  task automatic wr(input crtc_byte_t idx, input crtc_byte_t val);
    acc(1'b0, 1'b0, idx, 8'h00);
    acc(1'b1, 1'b0, val, 8'h00);
  endtask : wr
  task automatic rd(input crtc_byte_t idx, input crtc_byte_t exp);
    acc(1'b0, 1'b0, idx, 8'h00);
    acc(1'b1, 1'b1, 8'h00, exp);
  endtask : rd
  // cycles from a falling video flag to the next hsync rise
  task automatic gap(input logic cur, output int d);
    int k;
    int j;
    logic s;
    for (k = 0; k < 3; k++) begin
      for (j = 0; j < 3000; j++) begin
        @(posedge clk);
        s = cur ? bus_if.cursor_video : bus_if.display_window;
        if (k == 2 ? bus_if.hsync === 1'b1 : s === (k == 0)) break;
      end
      if (j == 3000) begin
        n_errors++;
        end_sim();
      end
    end
    d = j;
  endtask : gap
  // runs to the next vsync rise; flags cursor seen direct and latched
  task automatic frame(output logic fon, output logic fonq);
    int k;
    logic v;
    fon = 1'b0;
    fonq = 1'b0;
    v = 1'b1;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk);
      if (bus_if.cursor_video === 1'b1) fon = 1'b1;
      if (cur_q === 1'b1) fonq = 1'b1;
      if (bus_if.vsync === 1'b1 && v === 1'b0) break;
      v = bus_if.vsync;
    end
    if (k == 1000) begin
      n_errors++;
      end_sim();
    end
  endtask : frame
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    crtc_note_t n;
    if (done === 1'b1) begin
      n = notes.pop_front();
      if (n.rd === 1'b1) check(16'(rdata), 16'(n.exp));
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // program under chip clear: no half-set frame reaches the video
    for (i = 15; i >= 0; i--) wr(8'(i), cfg[i]);
    clear_req <= 1'b0;
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    repeat (4) begin
      rnd = $random(seed);
      wr(8'h0d, rnd[7:0]);
      rd(8'h0d, rnd[7:0]);
    end
    wr(8'h0d, cfg[13]);
    repeat (800) @(posedge clk);
    gap(1'b0, w0);
    gap(1'b1, c0);
    for (m = 1; m < 4; m++) begin
      wr(8'h08, {2'(m), 2'(m), 4'h0});
      repeat (800) @(posedge clk);
      gap(1'b0, dw);
      check(16'(w0 - dw), 16'(CHAR_CLKS * (m == 3 ? 2 : m)));
      gap(1'b1, dw);
      check(16'(c0 - dw), 16'(CHAR_CLKS * (m == 3 ? 2 : m)));
    end
    wr(8'h08, cfg[8]);
    for (m = 0; m < 4; m++) begin
      wr(8'h0a, {1'b0, 2'(m), 5'h01});
      frame(on, onq);
      hits = 0;
      hitsq = 0;
      // 16 or 32 fields hold whole blink periods: half show the cursor
      for (i = 0; i < (m < 2 ? 8 : 16 * (m - 1)); i++) begin
        frame(on, onq);
        hits += int'(on);
        hitsq += int'(onq);
      end
      nexp = (m == 1) ? 0 : (m == 0) ? 8 : 8 * (m - 1);
      check(16'(hits), 16'(nexp));
      check(16'(hitsq), 16'(nexp));
    end
    wr(8'h0a, cfg[10]);
    clear_req <= 1'b1;
    repeat (10) @(posedge clk);
    check(16'(bus_if.char_row_line), 16'h0000);
    check(16'(bus_if.refresh_mem_addr), 16'({cfg[12][5:0], cfg[13]}));
    clear_req <= 1'b0;
    for (i = 0; i < 16; i++) rd(8'(i), cfg[i]);
    repeat (8) @(posedge clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
